// *** hdl/phy_led_and_control_regs.vh ***
// Offsets, field positions, reset values and timing constants of the LED and PHY control registers.
`ifndef PHY_LED_AND_CONTROL_REGS_VH
`define PHY_LED_AND_CONTROL_REGS_VH

// Register offsets on the management port.
`define LED_CONTROL_ADDR 5'h18
`define PHY_CONTROL_ADDR 5'h19
`define INT_STATUS_ADDR 5'h1E
`define INT_MASK_ADDR 5'h1F

// Fields of led_control.
`define LEDC_RATE_HI 10
`define LEDC_RATE_LO 9
`define LEDC_POL_BIT 7
`define LEDC_FORCE_BIT 4
`define LEDC_ONOFF_BIT 1
`define LEDC_RATE_RST 2'h2

// Fields of phy_control.
`define PHYC_AUTO_XOVER_BIT 15
`define PHYC_FORCE_XOVER_BIT 14
`define PHYC_PAUSE_RX_BIT 13
`define PHYC_PAUSE_TX_BIT 12
`define PHYC_LINK_FD_BIT 11
`define PHYC_BYPASS_BIT 7

// Fields of the interrupt status and mask registers.
`define INT_LINK_FD_BIT 0
`define INT_PAUSE_BIT 1
`define INT_LINK_BIT 2
`define INT_WIDTH 3
`define INT_MASK_RST 3'h0

// Pause ability bits inside the ability words.
`define ABIL_PAUSE_BIT 0
`define ABIL_ASYM_BIT 1

// Timing: clock rate and blink durations in milliseconds.
`define CLK_HZ 40000000
`define MS_PER_S 1000
`define BLINK_20HZ_MS 10'h032
`define BLINK_10HZ_MS 10'h064
`define BLINK_5HZ_MS 10'h0C8
`define BLINK_2HZ_MS 10'h1F4

// Cycles after reset release before the synchronised straps are taken.
`define STRAP_WAIT 2'h3

`endif

// *** hdl/led_blink_timer.v ***
// Millisecond prescaler and blink phase generator for the link LED.
`default_nettype none

module led_blink_timer #(
  parameter CYCLES_PER_MS = 40000
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [1:0] i_rate,
  output reg o_phase,
  output reg o_period_end
);

  `include "phy_led_and_control_regs.vh"

  reg [31:0] pre_reg; // Cycle count inside one millisecond.
  reg [9:0] ms_reg; // Millisecond count inside one blink half period.
  reg [9:0] limit; // Half period length for the chosen rate.
  wire ms_tick; // One cycle pulse at the end of each millisecond.

  // Decodes the blink rate field into a half period in milliseconds.
  function [9:0] rate_ms;
    input [1:0] rate;
    begin
      case (rate)
        2'h0: rate_ms = `BLINK_20HZ_MS;
        2'h1: rate_ms = `BLINK_10HZ_MS;
        2'h2: rate_ms = `BLINK_5HZ_MS;
        default: rate_ms = `BLINK_2HZ_MS;
      endcase
    end
  endfunction

  assign ms_tick = (pre_reg == CYCLES_PER_MS - 1);

  // Selects the half period.
  always @* begin
    limit = rate_ms(i_rate);
  end

  // Counts milliseconds and toggles the phase at each half period end.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      pre_reg <= 32'h0;
      ms_reg <= 10'h0;
      o_phase <= 1'b0;
      o_period_end <= 1'b0;
    end else begin
      o_period_end <= 1'b0;
      if (ms_tick) begin
        pre_reg <= 32'h0;
        // A rate change to a shorter period that ms_reg has already passed ends the current one at the next millisecond tick.
        if (ms_reg >= limit - 10'h1) begin
          ms_reg <= 10'h0;
          o_phase <= ~o_phase;
          o_period_end <= 1'b1;
        end else begin
          ms_reg <= ms_reg + 10'h1;
        end
      end else begin
        pre_reg <= pre_reg + 32'h1;
      end
    end
  end

endmodule

`default_nettype wire

// *** hdl/phy_led_and_control_regs.v ***
// LED control and PHY control registers with LED drive, crossover and pause resolution.
`default_nettype none

// The constants are needed before the header, for the parameter default.
`include "phy_led_and_control_regs.vh"

// What this block does
// - Blink rate field picks LED blink period
// - Polarity bit sets LED active level
// - Polarity resets from strap, writes override
// - Force bit drives on/off bit onto LED
// - Auto crossover enable resets from strap
// - Forced crossover swaps transmit and receive pairs
// - Pause receive status resolved from ability bits
// - Pause transmit status resolved from ability bits
// - Pause status only with full-duplex result
// - Link status bit means 100 full-duplex
// - Bypass bit removes LED pulse stretching
module phy_led_and_control_regs #(
  parameter CYCLES_PER_MS = `CLK_HZ / `MS_PER_S
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [4:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  input wire i_strap_led_pol,
  input wire i_strap_auto_xover,
  input wire [1:0] i_local_pause,
  input wire [1:0] i_partner_pause,
  input wire i_hcd_full_duplex,
  input wire i_link_100_fd,
  input wire i_link_up,
  input wire i_activity,
  output reg o_link_led_output,
  output reg o_auto_xover_en,
  output reg o_pairs_swapped,
  output reg o_irq
);

  // Strap pins cross into the clock domain through two flip-flops each.
  reg strap_pol_meta_reg;
  reg strap_pol_reg;
  reg strap_ax_meta_reg;
  reg strap_ax_reg;
  reg [1:0] strap_wait_reg; // Counts cycles until the straps are settled.
  reg strap_pending_reg; // High until the straps have been taken.
  reg led_strap_due_reg; // Clears once the polarity is strapped or written.
  reg phy_strap_due_reg; // Clears once auto crossover is strapped or written.

  // Writable fields of led_control.
  reg [1:0] blink_rate_reg;
  reg led_pol_reg;
  reg led_force_reg;
  reg led_onoff_reg;

  // Writable fields of phy_control.
  reg auto_xover_reg;
  reg force_xover_reg;
  reg bypass_stretch_reg;

  // Resolved status fields.
  reg pause_rx_reg;
  reg pause_tx_reg;
  reg link_fd_reg;
  reg link_reg;

  // Interrupt status and mask.
  reg [`INT_WIDTH-1:0] int_status_reg;
  reg [`INT_WIDTH-1:0] int_mask_reg;
  reg [`INT_WIDTH-1:0] int_event;

  // LED path state.
  reg act_stretch_reg; // Activity held until the end of a blink half period.
  reg led_ind; // Indication before polarity.
  wire blink_phase; // Blink half period phase.
  wire period_end; // Pulse at the end of each blink half period.

  // Resolution results before registering.
  reg pause_rx_next;
  reg pause_tx_next;

  // Register images.
  wire [15:0] led_control_img;
  wire [15:0] phy_control_img;
  wire wr_led;
  wire wr_phy;
  wire wr_mask;
  wire rd_status;

  // Tells whether an address selects a given register.
  function hit;
    input [4:0] addr;
    input [4:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  assign wr_led = i_wr && hit(i_addr, `LED_CONTROL_ADDR);
  assign wr_phy = i_wr && hit(i_addr, `PHY_CONTROL_ADDR);
  assign wr_mask = i_wr && hit(i_addr, `INT_MASK_ADDR);
  assign rd_status = i_rd && hit(i_addr, `INT_STATUS_ADDR);

  // Reserved positions are constant zero in both images.
  assign led_control_img = {5'h0, blink_rate_reg, 1'b0, led_pol_reg, 2'h0, led_force_reg,
                            2'h0, led_onoff_reg, 1'b0};
  assign phy_control_img = {auto_xover_reg, force_xover_reg, pause_rx_reg, pause_tx_reg,
                            link_fd_reg, 3'h0, bypass_stretch_reg, 7'h0};

  // Brings the strap pins into the clock domain.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      strap_pol_meta_reg <= 1'b0;
      strap_pol_reg <= 1'b0;
      strap_ax_meta_reg <= 1'b0;
      strap_ax_reg <= 1'b0;
    end else begin
      strap_pol_meta_reg <= i_strap_led_pol;
      strap_pol_reg <= strap_pol_meta_reg;
      strap_ax_meta_reg <= i_strap_auto_xover;
      strap_ax_reg <= strap_ax_meta_reg;
    end
  end

  // Waits after reset release so the synchronisers hold the pin levels.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      strap_wait_reg <= 2'h0;
      strap_pending_reg <= 1'b1;
    end else if (strap_pending_reg) begin
      if (strap_wait_reg == `STRAP_WAIT) begin
        strap_pending_reg <= 1'b0;
      end else begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
      end
    end
  end

  // Holds the led_control fields; a write wins over the strap load.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      blink_rate_reg <= `LEDC_RATE_RST;
      led_pol_reg <= 1'b0;
      led_force_reg <= 1'b0;
      led_onoff_reg <= 1'b0;
      led_strap_due_reg <= 1'b1;
    end else if (wr_led) begin
      blink_rate_reg <= i_wdata[`LEDC_RATE_HI:`LEDC_RATE_LO];
      led_pol_reg <= i_wdata[`LEDC_POL_BIT];
      led_force_reg <= i_wdata[`LEDC_FORCE_BIT];
      led_onoff_reg <= i_wdata[`LEDC_ONOFF_BIT];
      // An early write cancels the later strap load, so software keeps its value.
      led_strap_due_reg <= 1'b0;
    end else if (led_strap_due_reg && strap_pending_reg && strap_wait_reg == `STRAP_WAIT) begin
      led_pol_reg <= strap_pol_reg;
      led_strap_due_reg <= 1'b0;
    end
  end

  // Holds the phy_control fields; a write wins over the strap load.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      auto_xover_reg <= 1'b0;
      force_xover_reg <= 1'b0;
      bypass_stretch_reg <= 1'b0;
      phy_strap_due_reg <= 1'b1;
    end else if (wr_phy) begin
      auto_xover_reg <= i_wdata[`PHYC_AUTO_XOVER_BIT];
      force_xover_reg <= i_wdata[`PHYC_FORCE_XOVER_BIT];
      bypass_stretch_reg <= i_wdata[`PHYC_BYPASS_BIT];
      // An early write cancels the later strap load, so software keeps its value.
      phy_strap_due_reg <= 1'b0;
    end else if (phy_strap_due_reg && strap_pending_reg && strap_wait_reg == `STRAP_WAIT) begin
      auto_xover_reg <= strap_ax_reg;
      phy_strap_due_reg <= 1'b0;
    end
  end

  // Resolves pause from local and partner pause and asymmetric bits.
  always @* begin
    pause_rx_next = 1'b0;
    pause_tx_next = 1'b0;
    if (i_local_pause[`ABIL_PAUSE_BIT] && i_partner_pause[`ABIL_PAUSE_BIT]) begin
      pause_rx_next = 1'b1;
      pause_tx_next = 1'b1;
    end else if (!i_local_pause[`ABIL_PAUSE_BIT] && i_local_pause[`ABIL_ASYM_BIT] &&
                 i_partner_pause[`ABIL_PAUSE_BIT] && i_partner_pause[`ABIL_ASYM_BIT]) begin
      pause_tx_next = 1'b1;
    end else if (i_local_pause[`ABIL_PAUSE_BIT] && i_local_pause[`ABIL_ASYM_BIT] &&
                 !i_partner_pause[`ABIL_PAUSE_BIT] && i_partner_pause[`ABIL_ASYM_BIT]) begin
      pause_rx_next = 1'b1;
    end
    // Half-duplex results never allow pause.
    if (!i_hcd_full_duplex) begin
      pause_rx_next = 1'b0;
      pause_tx_next = 1'b0;
    end
  end

  // Registers the read-only status fields.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      pause_rx_reg <= 1'b0;
      pause_tx_reg <= 1'b0;
      link_fd_reg <= 1'b0;
      link_reg <= 1'b0;
    end else begin
      pause_rx_reg <= pause_rx_next;
      pause_tx_reg <= pause_tx_next;
      link_fd_reg <= i_link_100_fd;
      link_reg <= i_link_up;
    end
  end

  // Flags changes of the status fields as interrupt events.
  always @* begin
    int_event = {`INT_WIDTH{1'b0}};
    int_event[`INT_LINK_FD_BIT] = (link_fd_reg != i_link_100_fd);
    int_event[`INT_PAUSE_BIT] = (pause_rx_reg != pause_rx_next) ||
                                (pause_tx_reg != pause_tx_next);
    int_event[`INT_LINK_BIT] = (link_reg != i_link_up);
  end

  // Sticky status cleared by a read; a new event in that cycle survives.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      int_status_reg <= {`INT_WIDTH{1'b0}};
      int_mask_reg <= `INT_MASK_RST;
      o_irq <= 1'b0;
    end else begin
      if (rd_status) begin
        int_status_reg <= int_event;
      end else begin
        int_status_reg <= int_status_reg | int_event;
      end
      if (wr_mask) begin
        int_mask_reg <= i_wdata[`INT_WIDTH-1:0];
      end
      o_irq <= |((rd_status ? int_event : (int_status_reg | int_event)) &
                 (wr_mask ? i_wdata[`INT_WIDTH-1:0] : int_mask_reg));
    end
  end

  // Returns read data one cycle after the read strobe; unmapped reads give zero.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        `LED_CONTROL_ADDR: o_rdata <= led_control_img;
        `PHY_CONTROL_ADDR: o_rdata <= phy_control_img;
        `INT_STATUS_ADDR: o_rdata <= {13'h0, int_status_reg};
        `INT_MASK_ADDR: o_rdata <= {13'h0, int_mask_reg};
        default: o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // Blink timer for the activity indication.
  led_blink_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_blink (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_rate(blink_rate_reg),
    .o_phase(blink_phase),
    .o_period_end(period_end)
  );

  // Stretches each activity pulse to the end of the current blink half period.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      act_stretch_reg <= 1'b0;
    end else if (i_activity) begin
      act_stretch_reg <= 1'b1;
    end else if (period_end) begin
      act_stretch_reg <= 1'b0;
    end
  end

  // Chooses the indication: forced, direct or stretched.
  always @* begin
    if (led_force_reg) begin
      led_ind = led_onoff_reg;
    end else if (bypass_stretch_reg) begin
      led_ind = i_link_up && !i_activity;
    end else begin
      led_ind = link_reg && !(act_stretch_reg && blink_phase);
    end
  end

  // Drives the LED pin and crossover controls from flip-flops.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_link_led_output <= 1'b1;
      o_auto_xover_en <= 1'b0;
      o_pairs_swapped <= 1'b0;
    end else begin
      o_link_led_output <= led_pol_reg ? led_ind : ~led_ind;
      o_auto_xover_en <= auto_xover_reg;
      o_pairs_swapped <= force_xover_reg;
    end
  end

endmodule

`default_nettype wire

// *** tb/mac_link_model.sv ***
// Behavioural link partner and negotiation result driving the status inputs.
`default_nettype none
module mac_link_model (
  input wire logic i_clk,
  output logic o_link_up,
  output logic o_activity,
  output logic o_link_100_fd,
  output logic [1:0] o_local_pause,
  output logic [1:0] o_partner_pause,
  output logic o_hcd_full_duplex
);
  timeunit 1ns;
  timeprecision 1ps;
  // The link starts down with nothing negotiated.
  initial begin
    {o_link_up, o_activity, o_link_100_fd} = 3'h0;
    {o_local_pause, o_partner_pause, o_hcd_full_duplex} = 5'h00;
  end
  // Takes a new line state just after a rising edge.
  task automatic set_state(input logic [7:0] s);
    @(posedge i_clk);
    {o_link_up, o_activity, o_link_100_fd} <= s[7:5];
    {o_local_pause, o_partner_pause, o_hcd_full_duplex} <= s[4:0];
  endtask
endmodule
`default_nettype wire

// *** tb/phy_regs_monitor.sv ***
// Port-level assertions for the LED and PHY control register block.
`default_nettype none
module phy_regs_monitor #(
  parameter CYCLES_PER_MS = 40000
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_hcd_full_duplex,
  input wire logic i_link_100_fd,
  input wire logic o_link_led_output,
  input wire logic o_auto_xover_en,
  input wire logic o_pairs_swapped
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Unmapped reads return zero.
  a_unmapped_read_zero: assert property (
    i_rd && !(i_addr inside {5'h18, 5'h19, 5'h1E, 5'h1F}) |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  // Reserved bits of both registers read zero.
  a_led_reserved_zero: assert property (
    i_rd && i_addr == 5'h18 |=> (o_rdata & 16'hF96D) == 16'h0000)
    else $error("led reserved bits set");
  a_phy_reserved_zero: assert property (
    i_rd && i_addr == 5'h19 |=> (o_rdata & 16'h077F) == 16'h0000)
    else $error("phy reserved bits set");
  // Link bit mirrors a steady full-duplex 100 Mb link.
  a_link_bit_follows: assert property (
    i_rd && i_addr == 5'h19 && $stable(i_link_100_fd) |=> o_rdata[11] == $past(i_link_100_fd))
    else $error("link bit wrong");
  // Pause bits stay low without a full-duplex result.
  a_pause_needs_fd: assert property (
    i_rd && i_addr == 5'h19 && !i_hcd_full_duplex && !$past(i_hcd_full_duplex)
    |=> o_rdata[13:12] == 2'b00)
    else $error("pause without full duplex");
  // Crossover outputs follow a write two edges later.
  a_xover_follows: assert property (
    i_wr && i_addr == 5'h19 |=> ##1 o_pairs_swapped == $past(i_wdata[14], 2))
    else $error("pair swap not applied");
  a_auto_xover_follows: assert property (
    i_wr && i_addr == 5'h19 |=> ##1 o_auto_xover_en == $past(i_wdata[15], 2))
    else $error("auto crossover not applied");
  // Forced drive with active-high polarity shows the on/off bit.
  a_led_forced: assert property (
    i_wr && i_addr == 5'h18 && i_wdata[4] && i_wdata[7]
    |=> ##1 o_link_led_output == $past(i_wdata[1], 2))
    else $error("forced led wrong");
endmodule
bind phy_led_and_control_regs phy_regs_monitor #(.CYCLES_PER_MS(CYCLES_PER_MS)) mon (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_hcd_full_duplex(i_hcd_full_duplex),
  .i_link_100_fd(i_link_100_fd), .o_link_led_output(o_link_led_output),
  .o_auto_xover_en(o_auto_xover_en), .o_pairs_swapped(o_pairs_swapped));
`default_nettype wire

// *** tb/phy_led_and_control_regs_tb_top.sv ***
// Self-checking bench for the LED and PHY control register block.
`default_nettype none
module phy_led_and_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic strap_pol = 1'b1; // Level on the LED polarity strap pin.
  logic strap_ax = 1'b1; // Level on the auto crossover strap pin.
  logic [15:0] o_rdata;
  logic lu, act, l100, hcd, led, auto_en, swapped, irq;
  logic [1:0] lp, pp;
  logic [15:0] d;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  // A 40 MHz clock.
  always #12.5 i_clk = ~i_clk;
  // Straps start high so the strapped defaults are visible; a later reset drops them.
  phy_led_and_control_regs #(.CYCLES_PER_MS(4)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_strap_led_pol(strap_pol), .i_strap_auto_xover(strap_ax), .i_local_pause(lp),
    .i_partner_pause(pp), .i_hcd_full_duplex(hcd), .i_link_100_fd(l100), .i_link_up(lu),
    .i_activity(act), .o_link_led_output(led), .o_auto_xover_en(auto_en),
    .o_pairs_swapped(swapped), .o_irq(irq));
  mac_link_model partner (.i_clk(i_clk), .o_link_up(lu), .o_activity(act),
    .o_link_100_fd(l100), .o_local_pause(lp), .o_partner_pause(pp), .o_hcd_full_duplex(hcd));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data is taken in the cycle after the strobe.
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    v = o_rdata;
  endtask
  task automatic settle;
    repeat (2) @(negedge i_clk);
  endtask
  // Counts cycles until the LED next changes, bounded.
  task automatic led_gap(output int n);
    logic s;
    s = led;
    n = 0;
    while (led === s && n < 3000) begin
      @(negedge i_clk);
      n++;
    end
  endtask
  task automatic t_reset;
    rd(5'h18, d);
    chk(d, 16'h0480);
    rd(5'h19, d);
    chk(d, 16'h8000);
    chk({15'h0, auto_en}, 16'h0001);
    $display("test reset done");
  endtask
  task automatic t_fields;
    wr(5'h18, 16'hFFFF);
    rd(5'h18, d);
    chk(d, 16'h0692);
    wr(5'h18, 16'h0000);
    rd(5'h18, d);
    chk(d, 16'h0000);
    wr(5'h19, 16'hFFFF);
    rd(5'h19, d);
    chk(d, 16'hC080);
    chk({14'h0, auto_en, swapped}, 16'h0003);
    wr(5'h19, 16'h0000);
    rd(5'h05, d);
    chk({d[15:2], auto_en, swapped}, 16'h0000);
    $display("test fields done");
  endtask
  task automatic t_led;
    partner.set_state(8'h80);
    wr(5'h18, 16'h0092);
    settle;
    chk({15'h0, led}, 16'h0001);
    wr(5'h18, 16'h0090);
    settle;
    chk({15'h0, led}, 16'h0000);
    wr(5'h18, 16'h0080);
    wr(5'h19, 16'h0080);
    settle;
    chk({15'h0, led}, 16'h0001);
    partner.set_state(8'hC0);
    settle;
    chk({15'h0, led}, 16'h0000);
    wr(5'h18, 16'h0000);
    settle;
    chk({15'h0, led}, 16'h0001);
    $display("test led done");
  endtask
  // Steady activity makes the LED toggle once per blink duration.
  task automatic t_blink;
    int ms[4] = '{50, 100, 200, 500};
    int n;
    wr(5'h19, 16'h0000);
    for (int r = 0; r < 4; r++) begin
      wr(5'h18, {5'h00, r[1:0], 9'h080});
      @(negedge i_clk);
      repeat (3) led_gap(n);
      chk(n[15:0], 16'(ms[r] * 4));
    end
    $display("test blink done");
  endtask
  // Line states with the expected pause rx, pause tx and link bits.
  task automatic t_pause;
    logic [7:0] st[5] = '{8'hAB, 8'h97, 8'h9D, 8'h95, 8'h8A};
    logic [2:0] ex[5] = '{3'b111, 3'b010, 3'b100, 3'b000, 3'b000};
    for (int i = 0; i < 5; i++) begin
      partner.set_state(st[i]);
      rd(5'h19, d);
      chk(d, {2'b00, ex[i], 11'h000});
    end
    $display("test pause done");
  endtask
  task automatic t_irq;
    wr(5'h1F, 16'h0004);
    rd(5'h1E, d);
    partner.set_state(8'h00);
    settle;
    chk({15'h0, irq}, 16'h0001);
    rd(5'h1E, d);
    chk({d[15:1], irq}, 16'h0004);
    wr(5'h1F, 16'h0000);
    partner.set_state(8'h80);
    settle;
    chk({15'h0, irq}, 16'h0000);
    rd(5'h1E, d);
    chk(d, 16'h0004);
    $display("test irq done");
  endtask
  // A second reset with both straps low; an early polarity write must beat the strap load.
  task automatic t_strap;
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    strap_pol <= 1'b0;
    strap_ax <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wr(5'h18, 16'h0480);
    repeat (5) @(posedge i_clk);
    rd(5'h18, d);
    chk(d, 16'h0480);
    rd(5'h19, d);
    chk(d, 16'h0000);
    chk({15'h0, auto_en}, 16'h0000);
    $display("test strap done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // A hang ends the run as a failure.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    t_reset;
    t_fields;
    t_led;
    t_blink;
    t_pause;
    t_irq;
    t_strap;
    tally_and_finish;
  end
endmodule
`default_nettype wire
